// *** hdl/containment_defs.svh ***
/*
 * Offsets, field positions, reset values and fixed codes of the
 * downstream port containment register block.
 * Assumes byte addressing of a 4 KB configuration space.
 */
`ifndef CONTAINMENT_DEFS_SVH
`define CONTAINMENT_DEFS_SVH

`define CTN_ADDR_W        12
`define CTN_OFS_HEADER    12'h250
`define CTN_OFS_CTRL      12'h254
`define CTN_OFS_STAT      12'h258
`define CTN_OFS_MASK      12'h25C

`define CTN_CAP_ID        16'h001D
`define CTN_CAP_VER       4'h1
`define CTN_NEXT_PTR      12'h000
`define CTN_MSI_VEC_RST   5'h01
`define CTN_SRC_ID_RST    16'h0000
`define CTN_MASK_RST      4'h0

`define CTN_TRIG_EN_LO    16
`define CTN_TRIG_EN_HI    17
`define CTN_CPL_CTL_BIT   18
`define CTN_INT_EN_BIT    19
`define CTN_ERRCOR_BIT    20
`define CTN_ST_TRIG_BIT   0
`define CTN_ST_RSN_LO     1
`define CTN_ST_RSN_HI     2
`define CTN_ST_INT_BIT    3
`define CTN_SRC_ID_LO     16

`define CTN_CPL_CA        3'h4
`define CTN_CPL_UR        3'h1

`endif

// *** hdl/containment_pkg.sv ***
/*
 * Types of the downstream port containment block: register port,
 * received error message, control fields and enumerations.
 * Uses literal codes and widths; containment_defs.svh is not included.
 */
package containment_pkg;

    typedef enum logic [1:0] {
        TRIG_OFF     = 2'h0,
        TRIG_FATAL   = 2'h1,
        TRIG_ANY_MSG = 2'h2,
        TRIG_RSVD    = 2'h3
    } trigMode_t;

    typedef enum logic [1:0] {
        REASON_UNCORR   = 2'h0,
        REASON_NONFATAL = 2'h1,
        REASON_FATAL    = 2'h2
    } reason_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [31:0] wrData;
    } regReq_t;

    typedef struct packed {
        logic        valid;
        logic        fatal;
        logic        nonFatal;
        logic [15:0] reqId;
    } errMsg_t;

    typedef struct packed {
        logic      errCorEn;
        logic      intEn;
        logic      cplUr;
        trigMode_t mode;
    } ctrl_t;

endpackage

// *** hdl/downstream_port_containment.sv ***
/*
 * Downstream port containment logic with its configuration registers:
 * capability header, capability, control, status, error source and
 * an interrupt mask word.
 * Assumes a single-cycle register port on sys_clk and error events
 * from core logic on the same clock.
 */
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "containment_defs.svh"

module downstream_port_containment #(
    parameter bit IS_DOWNSTREAM = 1'b1
) (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_b,
    input  wire containment_pkg::regReq_t regReq,
    output logic [31:0]                   regRdData,
    input  wire logic                     uncorrErr,
    input  wire containment_pkg::errMsg_t errMsg,
    output logic                          containActive,
    output logic [2:0]                    cplStatus,
    output logic                          msiReq,
    output logic [4:0]                    msiVector,
    output logic                          errCorReq,
    output logic                          irq
);

    containment_pkg::ctrl_t   ctrl_q;
    logic                     trigSt_q;
    containment_pkg::reason_t reason_q;
    logic                     intSt_q;
    logic [15:0]              srcId_q;
    logic [3:0]               mask_q;
    logic [31:0]              rdData_q;
    logic                     msiReq_q;
    logic                     errCorReq_q;
    logic [4:0]               msiVec_q;

    logic                     hitHeader;
    logic                     hitCtrl;
    logic                     hitStat;
    logic                     hitMask;
    logic [15:0]              w1c;
    logic                     hitUncorr;
    logic                     hitFatal;
    logic                     hitNonFatal;
    logic                     trigger;
    logic                     record;
    containment_pkg::reason_t reason_d;
    logic [3:0]               events;

    // Upstream ports see no structure at all
    always_comb begin
        hitHeader = IS_DOWNSTREAM && (regReq.addr == `CTN_OFS_HEADER);
        hitCtrl   = IS_DOWNSTREAM && (regReq.addr == `CTN_OFS_CTRL);
        hitStat   = IS_DOWNSTREAM && (regReq.addr == `CTN_OFS_STAT);
        hitMask   = IS_DOWNSTREAM && (regReq.addr == `CTN_OFS_MASK);
    end

    assign w1c = (regReq.wr && hitStat) ? regReq.wrData[15:0] : 16'h0000;

    // Trigger conditions per mode; 11b behaves as disabled
    always_comb begin
        hitUncorr   = uncorrErr && (ctrl_q.mode == containment_pkg::TRIG_FATAL ||
                                    ctrl_q.mode == containment_pkg::TRIG_ANY_MSG);
        hitFatal    = errMsg.valid && errMsg.fatal &&
                      (ctrl_q.mode == containment_pkg::TRIG_FATAL ||
                       ctrl_q.mode == containment_pkg::TRIG_ANY_MSG);
        hitNonFatal = errMsg.valid && errMsg.nonFatal &&
                      (ctrl_q.mode == containment_pkg::TRIG_ANY_MSG);
        trigger     = hitUncorr || hitFatal || hitNonFatal;
    end

    // Internal error outranks a message in the same cycle
    always_comb begin
        if (hitUncorr) begin
            reason_d = containment_pkg::REASON_UNCORR;
        end else if (hitFatal) begin
            reason_d = containment_pkg::REASON_FATAL;
        end else begin
            reason_d = containment_pkg::REASON_NONFATAL;
        end
    end

    // A clear in the same cycle frees the capture for the new event
    assign record = trigger && (!trigSt_q || w1c[`CTN_ST_TRIG_BIT]);

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ctrl_q <= '{errCorEn: 1'b0, intEn: 1'b0, cplUr: 1'b0,
                        mode: containment_pkg::TRIG_OFF};
        end else if (regReq.wr && hitCtrl) begin
            ctrl_q.mode     <= containment_pkg::trigMode_t'(
                                   regReq.wrData[`CTN_TRIG_EN_HI:`CTN_TRIG_EN_LO]);
            ctrl_q.cplUr    <= regReq.wrData[`CTN_CPL_CTL_BIT];
            ctrl_q.intEn    <= regReq.wrData[`CTN_INT_EN_BIT];
            ctrl_q.errCorEn <= regReq.wrData[`CTN_ERRCOR_BIT];
        end
    end

    // Set wins over a write-one clear
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            trigSt_q <= 1'b0;
        end else if (trigger) begin
            trigSt_q <= 1'b1;
        end else if (w1c[`CTN_ST_TRIG_BIT]) begin
            trigSt_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            reason_q <= containment_pkg::REASON_UNCORR;
        end else if (record) begin
            reason_q <= reason_d;
        end else begin
            reason_q <= containment_pkg::reason_t'(
                            reason_q & ~w1c[`CTN_ST_RSN_HI:`CTN_ST_RSN_LO]);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            intSt_q <= 1'b0;
        end else if (trigger && ctrl_q.intEn) begin
            intSt_q <= 1'b1;
        end else if (w1c[`CTN_ST_INT_BIT]) begin
            intSt_q <= 1'b0;
        end
    end

    // Left alone on an internal error: software must ignore it then
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            srcId_q <= `CTN_SRC_ID_RST;
        end else if (record && !hitUncorr) begin
            srcId_q <= errMsg.reqId;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            mask_q <= `CTN_MASK_RST;
        end else if (regReq.wr && hitMask) begin
            mask_q <= regReq.wrData[3:0];
        end
    end

    // One message per interrupt status edge, not per retrigger
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            msiReq_q <= 1'b0;
        end else begin
            msiReq_q <= trigger && ctrl_q.intEn && (!intSt_q || w1c[`CTN_ST_INT_BIT]);
        end
    end

    // ERR_COR only for a freshly recorded containment
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            errCorReq_q <= 1'b0;
        end else begin
            errCorReq_q <= record && ctrl_q.errCorEn;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            msiVec_q <= `CTN_MSI_VEC_RST;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rdData_q <= 32'h0000_0000;
        end else if (regReq.rd) begin
            rdData_q <= 32'h0000_0000;
            if (hitHeader) begin
                rdData_q <= {`CTN_NEXT_PTR, `CTN_CAP_VER, `CTN_CAP_ID};
            end else if (hitCtrl) begin
                rdData_q[4:0]                          <= msiVec_q;
                rdData_q[`CTN_TRIG_EN_HI:`CTN_TRIG_EN_LO] <= ctrl_q.mode;
                rdData_q[`CTN_CPL_CTL_BIT]             <= ctrl_q.cplUr;
                rdData_q[`CTN_INT_EN_BIT]              <= ctrl_q.intEn;
                rdData_q[`CTN_ERRCOR_BIT]              <= ctrl_q.errCorEn;
            end else if (hitStat) begin
                rdData_q[`CTN_ST_TRIG_BIT]             <= trigSt_q;
                rdData_q[`CTN_ST_RSN_HI:`CTN_ST_RSN_LO] <= reason_q;
                rdData_q[`CTN_ST_INT_BIT]              <= intSt_q;
                rdData_q[31:`CTN_SRC_ID_LO]            <= srcId_q;
            end else if (hitMask) begin
                rdData_q[3:0] <= mask_q;
            end
        end
    end

    // Interrupt sources share the status layout; reason bits never fire
    assign events = {intSt_q, 2'b00, trigSt_q};

    assign regRdData     = rdData_q;
    assign containActive = trigSt_q;
    assign cplStatus     = ctrl_q.cplUr ? `CTN_CPL_UR : `CTN_CPL_CA;
    assign msiReq        = msiReq_q;
    assign msiVector     = msiVec_q;
    assign errCorReq     = errCorReq_q;
    assign irq           = |(events & mask_q);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_header_value: assert property (
        regReq.rd && regReq.addr == `CTN_OFS_HEADER && IS_DOWNSTREAM
        |=> regRdData == 32'h0001_001D
    ) else $error("header word wrong");

    a_cap_vector: assert property (
        regReq.rd && hitCtrl |=> regRdData[4:0] == 5'h01 && msiVector == 5'h01
    ) else $error("interrupt vector wrong");

    a_mode_off: assert property (
        ctrl_q.mode == containment_pkg::TRIG_OFF && !trigSt_q
        |=> !trigSt_q && !errCorReq && !msiReq
    ) else $error("containment triggered while disabled");

    a_fatal_trig: assert property (
        (ctrl_q.mode == containment_pkg::TRIG_FATAL ||
         ctrl_q.mode == containment_pkg::TRIG_ANY_MSG) && errMsg.valid && errMsg.fatal
        |=> trigSt_q && containActive
    ) else $error("fatal message did not trigger");

    a_nonfatal_ignore: assert property (
        ctrl_q.mode == containment_pkg::TRIG_FATAL && !trigSt_q && !uncorrErr &&
        errMsg.valid && errMsg.nonFatal && !errMsg.fatal
        |=> !trigSt_q
    ) else $error("nonfatal triggered in fatal-only mode");

    a_nonfatal_trig: assert property (
        ctrl_q.mode == containment_pkg::TRIG_ANY_MSG && !trigSt_q && !uncorrErr &&
        errMsg.valid && errMsg.nonFatal && !errMsg.fatal
        |=> trigSt_q && reason_q == containment_pkg::REASON_NONFATAL
    ) else $error("nonfatal trigger or reason wrong");

    a_cpl_select: assert property (
        regReq.wr && hitCtrl
        |=> cplStatus == ($past(regReq.wrData[`CTN_CPL_CTL_BIT]) ? 3'h1 : 3'h4)
    ) else $error("completion status not following control");

    a_int_pulse: assert property (
        trigger && ctrl_q.intEn && !intSt_q
        |=> msiReq && intSt_q ##1 (!msiReq || $past(w1c[`CTN_ST_INT_BIT]))
    ) else $error("interrupt pulse or status missing");

    a_int_gated: assert property (
        !intSt_q && !(trigger && ctrl_q.intEn) |=> !intSt_q && !msiReq
    ) else $error("interrupt status set without enable");

    a_errcor_cause: assert property (
        errCorReq |-> $past(record) && $past(ctrl_q.errCorEn) && trigSt_q
    ) else $error("ERR_COR without fresh trigger");

    a_trig_clear: assert property (
        trigSt_q && w1c[`CTN_ST_TRIG_BIT] && !trigger |=> !trigSt_q
    ) else $error("trigger status not cleared");

    a_capture_hold: assert property (
        trigSt_q && w1c == 16'h0000 |=> $stable(reason_q) && $stable(srcId_q)
    ) else $error("capture overwritten while status set");

    a_src_capture: assert property (
        record && !hitUncorr |=> srcId_q == $past(errMsg.reqId)
    ) else $error("requester ID not captured");

    a_irq_mask: assert property (
        mask_q == 4'h0 |-> !irq
    ) else $error("interrupt with everything masked");

    a_irq_level: assert property (
        (trigSt_q && mask_q[`CTN_ST_TRIG_BIT]) || (intSt_q && mask_q[`CTN_ST_INT_BIT]) |-> irq
    ) else $error("unmasked status without interrupt");

    a_reason_fatal: assert property (
        ctrl_q.mode != containment_pkg::TRIG_OFF && ctrl_q.mode != containment_pkg::TRIG_RSVD &&
        !trigSt_q && !uncorrErr && errMsg.valid && errMsg.fatal
        |=> reason_q == containment_pkg::REASON_FATAL && srcId_q == $past(errMsg.reqId)
    ) else $error("fatal reason or source ID wrong");

    a_reason_uncorr: assert property (
        ctrl_q.mode != containment_pkg::TRIG_OFF && ctrl_q.mode != containment_pkg::TRIG_RSVD &&
        !trigSt_q && uncorrErr
        |=> trigSt_q && reason_q == containment_pkg::REASON_UNCORR && $stable(srcId_q)
    ) else $error("uncorrectable trigger or reason wrong");

    // Reserved mode stays inert so a stray write cannot arm containment
    a_rsvd_mode: assert property (
        ctrl_q.mode == containment_pkg::TRIG_RSVD && !trigSt_q |=> !trigSt_q && !errCorReq
    ) else $error("containment triggered in reserved mode");

    a_set_wins: assert property (
        trigger |=> trigSt_q
    ) else $error("trigger status lost to a clear");

    a_int_clear: assert property (
        intSt_q && w1c[`CTN_ST_INT_BIT] && !(trigger && ctrl_q.intEn) |=> !intSt_q
    ) else $error("interrupt status not cleared");

    a_reason_clear: assert property (
        !record && w1c[`CTN_ST_RSN_HI:`CTN_ST_RSN_LO] == 2'h3
        |=> reason_q == containment_pkg::REASON_UNCORR
    ) else $error("trigger reason not cleared");

    a_errcor_fresh: assert property (
        record && ctrl_q.errCorEn |=> errCorReq
    ) else $error("ERR_COR not requested on trigger");

    a_errcor_held: assert property (
        trigSt_q && w1c == 16'h0000 |=> !errCorReq
    ) else $error("ERR_COR repeated while contained");

    a_ctrl_write: assert property (
        regReq.wr && hitCtrl
        |=> ctrl_q.intEn == $past(regReq.wrData[`CTN_INT_EN_BIT]) &&
            ctrl_q.errCorEn == $past(regReq.wrData[`CTN_ERRCOR_BIT]) &&
            ctrl_q.mode == $past(regReq.wrData[`CTN_TRIG_EN_HI:`CTN_TRIG_EN_LO])
    ) else $error("control fields not written");

    a_unmapped_zero: assert property (
        regReq.rd && !hitHeader && !hitCtrl && !hitStat && !hitMask |=> regRdData == 32'h0000_0000
    ) else $error("unmapped read not zero");

    a_vector_fixed: assert property (
        msiVector == 5'h01
    ) else $error("interrupt vector output changed");

    c_fatal_contain: cover property (
        !trigSt_q ##1 errMsg.valid && errMsg.fatal ##1 trigSt_q ##[1:20] w1c[0]
    );

    c_retrigger_held: cover property (
        trigSt_q && trigger && w1c == 16'h0000
    );

    c_set_vs_clear: cover property (
        trigger && w1c[`CTN_ST_TRIG_BIT] && trigSt_q
    );

    c_irq_raised: cover property (
        msiReq ##[1:10] irq
    );

    c_uncorr_contain: cover property (
        !trigSt_q && uncorrErr && ctrl_q.mode == containment_pkg::TRIG_ANY_MSG ##1 trigSt_q
    );

endmodule

`default_nettype wire

// *** dv/link_partner_model.sv ***
/*
 * Link partner below the downstream port: sends error messages.
 * Assumes the caller enters send() right after a rising sys_clk edge.
 */
`timescale 1ns/1ps
`default_nettype none

module link_partner_model (
    input  wire logic                    sys_clk,
    output var  containment_pkg::errMsg_t errMsg
);
    initial errMsg = '0;

    // One-cycle message; fields turn to junk after it so stale values never match
    task automatic send(input logic fat, input logic [15:0] id);
        @(posedge sys_clk);
        errMsg <= '{1'b1, fat, !fat, id};
        @(posedge sys_clk);
        errMsg <= '{1'b0, !fat, fat, ~id};
    endtask
endmodule

`default_nettype wire

// *** dv/downstream_port_containment_tb.sv ***
/*
 * Self-checking bench of the containment block: reset values, a table of
 * trigger cases, then hold-while-set, masking and read-only checks.
 * Assumes the link partner model and a 25 MHz core clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "containment_defs.svh"

module downstream_port_containment_tb;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [1:0]  ev;
        logic        hit;
    } row_t;

    logic                     sys_clk = 1'b0;
    logic                     rst_b = 1'b0;
    containment_pkg::regReq_t regReq = '0;
    logic                     uncorrErr = 1'b0;
    containment_pkg::errMsg_t errMsg;
    logic [31:0]              regRdData;
    logic                     containActive;
    logic [2:0]               cplStatus;
    logic                     msiReq;
    logic [4:0]               msiVector;
    logic                     errCorReq;
    logic                     irq;
    int                       n_mismatch = 0;
    int                       samples_checked = 0;
    logic [15:0]              lastId = 16'h0000;
    logic [15:0]              id;
    // Event 0 uncorrectable, 1 nonfatal, 2 fatal; reason equals event code
    row_t rows [8] = '{'{32'h0000_0000, 2'h2, 1'b0}, '{32'h0001_0000, 2'h1, 1'b0},
                       '{32'h0009_0000, 2'h2, 1'b1}, '{32'h0015_0000, 2'h0, 1'b1},
                       '{32'h001A_0000, 2'h1, 1'b1}, '{32'h0006_0000, 2'h2, 1'b1},
                       '{32'h0003_0000, 2'h0, 1'b0}, '{32'h000A_0000, 2'h0, 1'b1}};

    always #20 sys_clk = ~sys_clk;

    downstream_port_containment downstream_port_containment_inst (
        .sys_clk       (sys_clk),
        .rst_b         (rst_b),
        .regReq        (regReq),
        .regRdData     (regRdData),
        .uncorrErr     (uncorrErr),
        .errMsg        (errMsg),
        .containActive (containActive),
        .cplStatus     (cplStatus),
        .msiReq        (msiReq),
        .msiVector     (msiVector),
        .errCorReq     (errCorReq),
        .irq           (irq)
    );

    link_partner_model link_partner_model_inst (
        .sys_clk (sys_clk),
        .errMsg  (errMsg)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrReg(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regReq <= '{1'b1, 1'b0, a, d};
        @(posedge sys_clk);
        regReq <= '0;
        #1;
    endtask

    // Read data stand from the cycle after the strobe until the next read
    task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        regReq <= '{1'b0, 1'b1, a, 32'h0000_0000};
        @(posedge sys_clk);
        regReq <= '0;
        #1;
        chk(regRdData, exp);
    endtask

    task automatic fire(input logic [1:0] ev, input logic [15:0] mid);
        if (ev == 2'h0) begin
            @(posedge sys_clk);
            uncorrErr <= 1'b1;
            @(posedge sys_clk);
            uncorrErr <= 1'b0;
        end else begin
            link_partner_model_inst.send(ev[1], mid);
        end
        #1;
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatched %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        rdChk(`CTN_OFS_HEADER, 32'h0001_001D);
        rdChk(`CTN_OFS_CTRL, 32'h0000_0001);
        rdChk(`CTN_OFS_STAT, 32'h0000_0000);
        chk(msiVector, 5'h01);
        wrReg(`CTN_OFS_MASK, 32'h0000_000F);
        for (int i = 0; i < 8; i++) begin
            id = 16'hA000 + 16'(i);
            wrReg(`CTN_OFS_CTRL, rows[i].ctrl);
            chk(cplStatus, rows[i].ctrl[18] ? `CTN_CPL_UR : `CTN_CPL_CA);
            fire(rows[i].ev, id);
            chk(containActive, rows[i].hit);
            chk(msiReq, rows[i].hit & rows[i].ctrl[19]);
            chk(errCorReq, rows[i].hit & rows[i].ctrl[20]);
            chk(irq, rows[i].hit);
            if (rows[i].hit && rows[i].ev != 2'h0) lastId = id;
            rdChk(`CTN_OFS_STAT, {lastId, 12'h000,
                  rows[i].hit ? {rows[i].ctrl[19], rows[i].ev, 1'b1} : 4'h0});
            wrReg(`CTN_OFS_STAT, 32'h0000_000F);
            rdChk(`CTN_OFS_STAT, {lastId, 16'h0000});
        end
        // Second trigger while the first is still recorded
        wrReg(`CTN_OFS_CTRL, 32'h0002_0000);
        fire(2'h1, 16'h1234);
        fire(2'h2, 16'h5678);
        rdChk(`CTN_OFS_STAT, 32'h1234_0003);
        // Trigger beside a clear: set wins, capture taken afresh
        fork
            wrReg(`CTN_OFS_STAT, 32'h0000_0007);
            fire(2'h2, 16'h4321);
        join
        rdChk(`CTN_OFS_STAT, 32'h4321_0005);
        wrReg(`CTN_OFS_MASK, 32'h0000_0000);
        chk(irq, 1'b0);
        wrReg(`CTN_OFS_MASK, 32'h0000_0001);
        chk(irq, 1'b1);
        wrReg(`CTN_OFS_STAT, 32'h0000_0007);
        rdChk(`CTN_OFS_STAT, 32'h4321_0000);
        chk(containActive, 1'b0);
        // Read-only and unmapped places ignore writes
        wrReg(`CTN_OFS_HEADER, 32'hFFFF_FFFF);
        rdChk(`CTN_OFS_HEADER, 32'h0001_001D);
        wrReg(12'h300, 32'hFFFF_FFFF);
        rdChk(12'h300, 32'h0000_0000);
        rdChk(`CTN_OFS_CTRL, 32'h0002_0001);
        // Reset in mid-run returns control to its reset value
        wrReg(`CTN_OFS_CTRL, 32'h001F_0000);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        @(posedge sys_clk);
        rst_b <= 1'b1;
        rdChk(`CTN_OFS_CTRL, 32'h0000_0001);
        chk(cplStatus, `CTN_CPL_CA);
        tally_and_finish();
    end
endmodule

`default_nettype wire
